// file: hw/xsb_pkg.sv
// package for the external data-memory bus interface
package xsb_pkg;
    localparam int unsigned XSB_CLK_MHZ      = 50;
    localparam int unsigned XSB_ADDR_W       = 16;
    localparam int unsigned XSB_DATA_W       = 8;
    localparam logic [15:0] XSB_INT_TOP      = 16'h0fff;
    localparam logic [7:0]  XSB_BYTE_RESET   = 8'h00;
    localparam logic [2:0]  XSB_CYC_BASE     = 3'h3;
    localparam logic [2:0]  XSB_CYC_WAIT     = 3'h4;

    typedef enum logic [1:0]
    {
        XSB_IDLE  = 2'b00,
        XSB_ADDR  = 2'b01,
        XSB_WAIT  = 2'b10,
        XSB_DATA  = 2'b11
    } xsb_state_t;
endpackage

// file: hw/xsb_pin_mux.sv
// port A pin multiplexer: bus function or plain port
`timescale 1ns/1ps
`default_nettype none
module xsb_pin_mux
(
    input  wire logic       busOwn,
    input  wire logic [7:0] busOut,
    input  wire logic [7:0] busOeN,
    input  wire logic [7:0] portData,
    input  wire logic [7:0] portDir,
    output logic      [7:0] muxOut,
    output logic      [7:0] muxOeN
);
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_bit
            // bus overrides direction bits, else port settings
            assign muxOut[gi] = busOwn ? busOut[gi] : portData[gi];
            assign muxOeN[gi] = busOwn ? busOeN[gi] : ~portDir[gi];
        end
    endgenerate
endmodule
`default_nettype wire

// file: hw/xsb_bus_if.sv
// external data-memory bus interface with address latch strobe
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - port A muxes low address/data, C high
// - enable bit overrides port A direction
// - enable cleared returns pins to port
// - disabled: no external access, no redirect
// - low address valid at strobe fall
// - latch strobe low through data phase
// - read/write strobes only for external
// - high address on port C steady during external access
// - three cycles without wait state
// - wait select adds exactly one cycle
// - port A data one cycle, then address
// - no turnaround between read and write
module xsb_bus_if
(
    input  wire logic                          mclk,
    input  wire logic                          reset_n,
    input  wire logic                          clkEn,
    input  wire logic                          external_memory_enable,
    input  wire logic                          wait_state_select,
    input  wire logic                          reqValid,
    input  wire logic                          reqWrite,
    input  wire logic [xsb_pkg::XSB_ADDR_W-1:0] reqAddr,
    input  wire logic [7:0]                    reqWdata,
    input  wire logic [7:0]                    portAData,
    input  wire logic [7:0]                    port_a_direction_register,
    input  wire logic [7:0]                    portCData,
    input  wire logic [7:0]                    portAIn,
    output logic                               reqDone,
    output logic                               reqBusy,
    output logic [7:0]                         rdData,
    output logic [7:0]                         portAOut,
    output logic [7:0]                         portAOeN,
    output logic [7:0]                         portCOut,
    output logic                               ale,
    output logic                               rdN,
    output logic                               wrN
);
    import xsb_pkg::*;

    xsb_state_t  state_ff, nxt_state;
    logic        ale_ff, nxt_ale;
    logic        rdN_ff, nxt_rdN;
    logic        wrN_ff, nxt_wrN;
    logic        write_ff, nxt_write;
    logic        done_ff, nxt_done;
    logic [7:0]  aOut_ff, nxt_aOut;
    logic [7:0]  aOeN_ff, nxt_aOeN;
    logic [7:0]  cOut_ff, nxt_cOut;
    logic [7:0]  rd_ff, nxt_rd;
    logic [7:0]  wdat_ff, nxt_wdat;
    logic [7:0]  muxOut, muxOeN;
    logic [7:0]  busByte;
    logic        extHit;
    logic        busOwn;
    logic        ownPort;

    // only above the internal boundary and only when enabled
    assign extHit  = reqValid && external_memory_enable && (reqAddr > XSB_INT_TOP);
    assign busOwn  = external_memory_enable || (state_ff != XSB_IDLE);
    assign ownPort = busOwn;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_ale   = 1'b0;
        nxt_rdN   = 1'b1;
        nxt_wrN   = 1'b1;
        nxt_write = write_ff;
        nxt_done  = 1'b0;
        nxt_aOut  = aOut_ff;
        nxt_aOeN  = aOeN_ff;
        nxt_cOut  = cOut_ff;
        nxt_rd    = rd_ff;
        nxt_wdat  = wdat_ff;
        case (state_ff)
            XSB_IDLE:
            begin
                nxt_aOeN = 8'h00;
                if (extHit)
                begin
                    // address cycle: latch open, low byte out
                    nxt_state = XSB_ADDR;
                    nxt_ale   = 1'b1;
                    nxt_write = reqWrite;
                    nxt_wdat  = reqWdata;
                    nxt_aOut  = reqAddr[7:0];
                    nxt_cOut  = reqAddr[15:8];
                end
            end
            XSB_ADDR:
            begin
                // strobe falls with address still on port A
                if (wait_state_select)
                begin
                    nxt_state = XSB_WAIT;
                end
                else
                begin
                    nxt_state = XSB_DATA;
                    nxt_rdN   = write_ff;
                    nxt_wrN   = ~write_ff;
                    nxt_aOeN  = write_ff ? 8'h00 : 8'hff;
                end
            end
            XSB_WAIT:
            begin
                nxt_state = XSB_DATA;
                nxt_rdN   = write_ff;
                nxt_wrN   = ~write_ff;
                nxt_aOeN  = write_ff ? 8'h00 : 8'hff;
            end
            XSB_DATA:
            begin
                // single data cycle, then address drive again
                nxt_state = XSB_IDLE;
                nxt_done  = 1'b1;
                nxt_aOeN  = 8'h00;
                if (!write_ff)
                begin
                    nxt_rd = portAIn;
                end
            end
            default:
            begin
                nxt_state = XSB_IDLE;
            end
        endcase
        // held address byte cleared to reset value when disabled and idle
        if (!ownPort && nxt_state == XSB_IDLE)
        begin
            nxt_aOut = XSB_BYTE_RESET;
        end
        // write data rides on port A for the data cycle only
        busByte = (nxt_state == XSB_DATA && write_ff) ? wdat_ff : nxt_aOut;
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            state_ff <= XSB_IDLE;
            ale_ff   <= 1'b0;
            rdN_ff   <= 1'b1;
            wrN_ff   <= 1'b1;
            write_ff <= 1'b0;
            done_ff  <= 1'b0;
            aOut_ff  <= XSB_BYTE_RESET;
            aOeN_ff  <= 8'h00;
            cOut_ff  <= XSB_BYTE_RESET;
            rd_ff    <= XSB_BYTE_RESET;
            wdat_ff  <= XSB_BYTE_RESET;
        end
        else if (clkEn)
        begin
            state_ff <= nxt_state;
            ale_ff   <= nxt_ale;
            rdN_ff   <= nxt_rdN;
            wrN_ff   <= nxt_wrN;
            write_ff <= nxt_write;
            done_ff  <= nxt_done;
            aOut_ff  <= nxt_aOut;
            aOeN_ff  <= nxt_aOeN;
            cOut_ff  <= nxt_cOut;
            rd_ff    <= nxt_rd;
            wdat_ff  <= nxt_wdat;
        end
    end

    xsb_pin_mux u_mux
    (
        .busOwn   (busOwn),
        .busOut   (busByte),
        .busOeN   (nxt_aOeN),
        .portData (portAData),
        .portDir  (port_a_direction_register),
        .muxOut   (muxOut),
        .muxOeN   (muxOeN)
    );

    // pins load next bus value, no lag behind strobes
    logic [7:0] pinOut_ff, pinOeN_ff, pinC_ff;
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            pinOut_ff <= 8'h00;
            pinOeN_ff <= 8'hff;
            pinC_ff   <= 8'h00;
        end
        else if (clkEn)
        begin
            pinOut_ff <= muxOut;
            pinOeN_ff <= muxOeN;
            pinC_ff   <= busOwn ? nxt_cOut : portCData;
        end
    end

    assign portAOut = pinOut_ff;
    assign portAOeN = pinOeN_ff;
    assign portCOut = pinC_ff;
    assign ale      = ale_ff;
    assign rdN      = rdN_ff;
    assign wrN      = wrN_ff;
    assign reqDone  = done_ff;
    assign reqBusy  = (state_ff != XSB_IDLE);
    assign rdData   = rd_ff;

    // checks
    a_strobe_excl: assert property (@(posedge mclk) disable iff (!reset_n)
        !(!rdN_ff && !wrN_ff)) else $error("both strobes low");
    a_strobe_data: assert property (@(posedge mclk) disable iff (!reset_n)
        (!rdN_ff || !wrN_ff) |-> (state_ff == XSB_DATA)) else $error("strobe outside data");
    a_ale_low: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_ff == XSB_DATA || state_ff == XSB_WAIT) |-> !ale_ff) else $error("ale high");
    a_three_cyc: assert property (@(posedge mclk) disable iff (!reset_n)
        (clkEn && state_ff == XSB_IDLE && extHit && !wait_state_select) ##1 clkEn ##1 clkEn
        |-> ##1 (state_ff == XSB_IDLE && done_ff)) else $error("access not 3 cycles");
    a_wait_cyc: assert property (@(posedge mclk) disable iff (!reset_n)
        (clkEn && state_ff == XSB_ADDR && wait_state_select) |=> state_ff == XSB_WAIT)
        else $error("no wait");
    a_high_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_ff != XSB_IDLE && clkEn && nxt_state != XSB_IDLE) |=> $stable(cOut_ff))
        else $error("high address moved");
    a_no_ext_off: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_ff == XSB_IDLE && !external_memory_enable) |=> state_ff == XSB_IDLE)
        else $error("access while off");
    a_data_one: assert property (@(posedge mclk) disable iff (!reset_n)
        (clkEn && state_ff == XSB_DATA) |=> state_ff != XSB_DATA) else $error("long data");
    c_read: cover property (@(posedge mclk) state_ff == XSB_DATA && !write_ff);
    c_write: cover property (@(posedge mclk) state_ff == XSB_DATA && write_ff);
    c_wait: cover property (@(posedge mclk) state_ff == XSB_WAIT);
endmodule
`default_nettype wire

// file: dv/xsb_sram_model.sv
// far side model: address latch and static ram
`timescale 1ns/1ps
`default_nettype none
module xsb_sram_model
(
    input  wire logic       mclk,
    input  wire logic       ale,
    input  wire logic       rdN,
    input  wire logic       wrN,
    input  wire logic [7:0] portAOut,
    input  wire logic [7:0] portAOeN,
    input  wire logic [7:0] portCOut,
    output logic      [7:0] portAPin
);
    logic [7:0] mem [0:65535];
    logic [7:0] lowAddr;
    logic [7:0] lastPin = 8'h00;
    logic [7:0] farSide;
    // released bus shows the inverse of its last level
    assign farSide  = rdN ? ~lastPin : mem[{portCOut, lowAddr}];
    assign portAPin = (~portAOeN & portAOut) | (portAOeN & farSide);
    always @(posedge mclk)
    begin
        lastPin <= portAPin;
        if (ale)
            lowAddr <= portAPin;
        if (!wrN)
            mem[{portCOut, lowAddr}] <= portAPin;
    end
endmodule
`default_nettype wire

// file: dv/external_sram_bus_interface_bench.sv
// bench for the external data-memory bus interface
`timescale 1ns/1ps
`default_nettype none
module external_sram_bus_interface_bench;
    import xsb_pkg::*;
    logic        mclk     = 1'b0;
    logic        reset_n  = 1'b0;
    logic        clkEn    = 1'b1;
    logic        enable   = 1'b0;
    logic        waitSel  = 1'b0;
    logic        reqValid = 1'b0;
    logic        reqWrite = 1'b0;
    logic [15:0] reqAddr  = 16'h0000;
    logic [7:0]  reqWdata = 8'h00;
    logic [7:0]  portDir  = 8'h5a;
    logic [7:0]  portAPin;
    logic        reqDone;
    logic        reqBusy;
    logic        ale;
    logic        rdN;
    logic        wrN;
    logic [7:0]  rdData;
    logic [7:0]  portAOut;
    logic [7:0]  portAOeN;
    logic [7:0]  portCOut;
    int          miscompares  = 0;
    int          total_checks = 0;
    int          cycles       = 0;

    xsb_bus_if i_dut (.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn),
        .external_memory_enable(enable), .wait_state_select(waitSel),
        .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
        .reqWdata(reqWdata), .portAData(8'hc3), .port_a_direction_register(portDir),
        .portCData(8'h96), .portAIn(portAPin), .reqDone(reqDone), .reqBusy(reqBusy),
        .rdData(rdData), .portAOut(portAOut), .portAOeN(portAOeN),
        .portCOut(portCOut), .ale(ale), .rdN(rdN), .wrN(wrN));
    xsb_sram_model i_ram (.mclk(mclk), .ale(ale), .rdN(rdN), .wrN(wrN),
        .portAOut(portAOut), .portAOeN(portAOeN), .portCOut(portCOut),
        .portAPin(portAPin));

    initial
        forever #10 mclk = ~mclk;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(negedge mclk)
    begin
        cycles <= cycles + 1;
        if (reset_n && (!rdN || !wrN))
        begin
            chk(16'(ale), 16'h0000);
            chk(16'(rdN | wrN), 16'h0001);
            chk(16'(reqBusy), 16'h0001);
        end
        if (cycles == 3000)
        begin
            miscompares++;
            final_report();
        end
    end

    // one access, timed from the edge that takes it
    task automatic access(input logic wr, input logic [15:0] addr,
                          input logic [7:0] data, input int cyc);
        int n;
        int gap;
        int rdLow;
        int wrLow;
        int aleHi;
        int drove;
        n = 0;
        gap = 0;
        rdLow = 0;
        wrLow = 0;
        aleHi = 0;
        drove = 0;
        reqWrite = wr;
        reqAddr = addr;
        reqWdata = data;
        reqValid = 1'b1;
        while (reqBusy !== 1'b1 && gap < 8)
        begin
            @(posedge mclk);
            #1 gap++;
        end
        reqValid = 1'b0;
        chk(16'(gap), 16'h0001);
        n = 1;
        while (reqDone !== 1'b1 && n < 10)
        begin
            aleHi += int'(ale === 1'b1);
            rdLow += int'(rdN === 1'b0);
            wrLow += int'(wrN === 1'b0);
            drove += int'(portAOeN === 8'h00);
            if (ale === 1'b1)
                chk(16'(portAOut), 16'(addr[7:0]));
            if (n >= 2)
                chk(16'(portCOut), 16'(addr[15:8]));
            @(posedge mclk);
            #1 n++;
        end
        chk(16'(n), 16'(cyc));
        chk(16'(aleHi), 16'h0001);
        chk(16'(drove > 0), 16'h0001);
        chk(16'(wr ? rdLow : wrLow), 16'h0000);
        chk(16'(wr ? wrLow : rdLow), 16'h0001);
        chk(16'(portAOut), 16'(addr[7:0]));
        chk(16'(portAOeN), 16'h0000);
        if (wr)
            chk(16'(i_ram.mem[addr]), 16'(data));
        else
            chk(16'(rdData), 16'(data));
    endtask

    task automatic refused(input logic [15:0] addr);
        reqAddr = addr;
        reqWrite = 1'b0;
        reqValid = 1'b1;
        repeat (6)
        begin
            @(posedge mclk);
            #1 chk(16'({reqBusy, rdN, wrN, reqDone}), 16'h0006);
        end
        reqValid = 1'b0;
    endtask

    initial
    begin
        repeat (5) @(posedge mclk);
        #1 reset_n = 1'b1;
        enable = 1'b1;
        access(1'b1, 16'h1234, 8'ha5, 3);
        access(1'b0, 16'h1234, 8'ha5, 3);
        access(1'b1, 16'hff00, 8'h3c, 3);
        waitSel = 1'b1;
        access(1'b0, 16'hff00, 8'h3c, 4);
        @(posedge mclk);
        #1 access(1'b1, 16'h1000, 8'h81, 4);
        waitSel = 1'b0;
        access(1'b0, 16'h1000, 8'h81, 3);
        refused(XSB_INT_TOP);
        clkEn = 1'b0;
        enable = 1'b0;
        repeat (3) @(posedge mclk);
        #1 chk(16'(portAOeN), 16'h0000);
        chk(16'(portCOut), 16'h0010);
        clkEn = 1'b1;
        repeat (3) @(posedge mclk);
        #1 chk(16'(portAOeN), {8'h00, ~portDir});
        chk(16'(portAOut), 16'h00c3);
        chk(16'(portCOut), 16'h0096);
        refused(16'h2000);
        final_report();
    end
endmodule
`default_nettype wire
